/* src/uhds_defines.svh */
// constants for the usb host descriptor scheduler
`ifndef UHDS_DEFINES_SVH
`define UHDS_DEFINES_SVH

`define UHDS_CLK_NS          50
`define UHDS_FRAME_NS        1000000

// register byte offsets on the wishbone bus
`define UHDS_REG_BUF_STATUS  12'h000
`define UHDS_REG_BLK_SIZE    12'h004
`define UHDS_REG_SKIP_MAP    12'h008
`define UHDS_REG_DONE_MAP    12'h00c
`define UHDS_REG_APER_LAST   12'h010
`define UHDS_REG_INT_LAST    12'h014
`define UHDS_REG_ISO_LAST    12'h018
`define UHDS_REG_IRQ_THRESH  12'h01c
`define UHDS_REG_IRQ_STATUS  12'h020
`define UHDS_REG_FRAME_NUM   12'h024
`define UHDS_RAM_WIN_SEL     2'b01

// buffer status and irq status bits
`define UHDS_BS_APER_ACT     0
`define UHDS_BS_INT_ACT      1
`define UHDS_BS_ISO_ACT      2
`define UHDS_BS_PONG_ON_LINE 3
`define UHDS_BS_BUSY         4
`define UHDS_IRQ_APER        0
`define UHDS_IRQ_INT         1

// reset values
`define UHDS_RST_BLK_SIZE    10'h008
`define UHDS_RST_SKIP_MAP    16'hffff
`define UHDS_RST_LAST        4'h0
`define UHDS_RST_THRESH      4'h1

// list bases in the buffer ram, word index
`define UHDS_BASE_APER       8'h00
`define UHDS_BASE_INT        8'h80
`define UHDS_BASE_ISO        8'hc0

// header word 0 = {B3,B2,B1,B0}
`define UHDS_H0_ACTUAL       9:0
`define UHDS_H0_TOGGLE       10
`define UHDS_H0_ACTIVE       11
`define UHDS_H0_CC           15:12
`define UHDS_H0_MAXPKT       25:16
`define UHDS_H0_SPEED        26
`define UHDS_H0_LAST         27
`define UHDS_H0_ENDPT        31:28
// header word 1 = {B7,B6,B5,B4}
`define UHDS_H1_TOTAL        9:0
`define UHDS_H1_TOKEN        11:10
`define UHDS_H1_PONG         14
`define UHDS_H1_PAIRED       15
`define UHDS_H1_FADDR        22:16
`define UHDS_H1_START        31:24
`define UHDS_H1_POLL         31:29
`define UHDS_H1_SFRAME       28:24

`define UHDS_CC_NO_ERROR     4'h0

`endif

/* src/uhds_pkg.sv */
// types of the usb host descriptor scheduler
package uhds_pkg;

	typedef enum logic [2:0] {
		S_IDLE,
		S_RD0,
		S_RD1,
		S_LATCH,
		S_EVAL,
		S_XFER,
		S_WB,
		S_NEXT
	} uhds_state_t;

	typedef enum logic [1:0] {
		L_INT,
		L_ISO,
		L_APER
	} uhds_list_t;

endpackage

/* src/uhds_td_decode.sv */
// transfer descriptor header field decode and frame match
`timescale 1ns/1ps
`include "uhds_defines.svh"

module uhds_td_decode
	import uhds_pkg::*;
(
	input  wire logic [31:0] hdr0_i,
	input  wire logic [31:0] hdr1_i,
	input  wire logic [15:0] frame_i,
	output logic             active_o,
	output logic             paired_o,
	output logic             pong_o,
	output logic             toggle_o,
	output logic             low_speed_o,
	output logic [6:0]       func_addr_o,
	output logic [3:0]       endpoint_o,
	output logic [1:0]       token_o,
	output logic [9:0]       max_pkt_o,
	output logic [9:0]       total_o,
	output logic             poll_due_o,
	output logic             iso_due_o
);

	// interval of 2^code frames; start frame only has five bits, so
	// for codes 6 and 7 the phase is limited to the first 32 frames
	function automatic logic poll_match(input logic [2:0] code, input logic [4:0] start,
		input logic [15:0] frame);
		logic [6:0] mask;
		mask = 7'((8'h01 << code) - 8'h01);
		poll_match = ((frame[6:0] ^ {2'b00, start}) & mask) == 7'h00;
	endfunction

	assign active_o    = hdr0_i[`UHDS_H0_ACTIVE];
	assign toggle_o    = hdr0_i[`UHDS_H0_TOGGLE];
	assign low_speed_o = hdr0_i[`UHDS_H0_SPEED];
	assign max_pkt_o   = hdr0_i[`UHDS_H0_MAXPKT];
	assign endpoint_o  = hdr0_i[`UHDS_H0_ENDPT];
	assign paired_o    = hdr1_i[`UHDS_H1_PAIRED];
	assign pong_o      = hdr1_i[`UHDS_H1_PONG];
	assign token_o     = hdr1_i[`UHDS_H1_TOKEN];
	assign total_o     = hdr1_i[`UHDS_H1_TOTAL];
	assign func_addr_o = hdr1_i[`UHDS_H1_FADDR];
	assign poll_due_o  = poll_match(hdr1_i[`UHDS_H1_POLL],
		hdr1_i[`UHDS_H1_SFRAME], frame_i);
	assign iso_due_o   = hdr1_i[`UHDS_H1_START] == frame_i[7:0];

endmodule

/* src/uhds_scheduler.sv */
// usb host descriptor scheduler: wishbone registers, buffer ram, list walker
`timescale 1ns/1ps
`include "uhds_defines.svh"
// Behaviour
// - paired descriptors let two active descriptors share one endpoint and address.
// - in the aperiodic list, a pong payload goes out only after its ping payload was sent.
// - buffer status shows whether the ping or pong is on the line.
// - each descriptor carries a seven bit target function address.
// - interrupt descriptors hold interval code and five bit start frame.
// - isochronous descriptors run only when start byte equals the low byte of the frame number.
// - interrupt polling interval is two to the power code milliseconds.
// - paired aperiodic descriptors allow up to 18 bulk packets per frame.
// - a done bitmap marks every completed aperiodic descriptor.
// - irq rises after a programmed number of aperiodic completions.
// - aperiodic descriptors flagged in the skip bitmap are never processed.
// - software sets list active, then the controller starts sending.
// - after sending, active is cleared and a four bit code written.
// - interrupt transactions raise irq only when acknowledged or in error.
// - acknowledged means data received on in or sent on out.
// - interrupt list irq fires at most once per frame.
// - software sets active; controller clears it so later passes skip it.
// - toggle bit selects data pid and flips after each good packet.
// - speed bit zero is full speed, one is low speed.

module uhds_scheduler
	import uhds_pkg::*;
#(
	parameter int FRAME_CYCLES = `UHDS_FRAME_NS / `UHDS_CLK_NS
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [11:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	output logic             txn_req_o,
	output logic [6:0]       txn_func_addr_o,
	output logic [3:0]       txn_endpoint_o,
	output logic [1:0]       txn_token_o,
	output logic             txn_toggle_o,
	output logic             txn_low_speed_o,
	output logic [9:0]       txn_max_pkt_o,
	output logic [9:0]       txn_total_o,
	output logic [7:0]       txn_data_ptr_o,
	input  wire logic        txn_done_i,
	input  wire logic        txn_nak_i,
	input  wire logic        txn_acked_i,
	input  wire logic [3:0]  txn_cc_i,
	input  wire logic [9:0]  txn_actual_i,
	input  wire logic [7:0]  sie_rd_addr_i,
	output logic [31:0]      sie_rd_data_o,
	input  wire logic        sie_wr_en_i,
	input  wire logic [7:0]  sie_wr_addr_i,
	input  wire logic [31:0] sie_wr_data_i,
	output logic             sof_o,
	output logic             irq_o
);

	function automatic logic [31:0] merge_sel(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		for (int b = 0; b < 4; b++) begin
			merge_sel[8*b +: 8] = sel[b] ? new_v[8*b +: 8] : old_v[8*b +: 8];
		end
	endfunction

	logic [31:0]  ram [0:255];
	uhds_state_t  state_r, state_nxt;
	uhds_list_t   list_r, list_nxt;
	logic [3:0]   idx_r, idx_nxt;
	logic [3:0]   aper_idx_r;
	logic [31:0]  hdr0_r, hdr1_r, sched_q, wb_dat_r, sie_rd_data_r;
	logic [3:0]   cc_r;
	logic [9:0]   actual_r;
	logic         acked_r;
	logic [14:0]  frm_cnt_r;
	logic [15:0]  frame_r;
	logic         frame_pend_r;
	logic         ack_r;
	logic [2:0]   list_act_r;
	logic [9:0]   blk_size_r;
	logic [15:0]  skip_r, done_r;
	logic [3:0]   aper_last_r, int_last_r, iso_last_r, thresh_r, aper_cnt_r;
	logic [1:0]   irq_stat_r;
	logic         ping_done_r;
	logic         int_fired_r;

	// decoded header
	logic         d_active, d_paired, d_pong, d_toggle, d_low, d_poll_due, d_iso_due;
	logic [6:0]   d_faddr;
	logic [3:0]   d_endp;
	logic [1:0]   d_token;
	logic [9:0]   d_maxpkt, d_total;

	uhds_td_decode u_decode (
		.hdr0_i      (hdr0_r),
		.hdr1_i      (hdr1_r),
		.frame_i     (frame_r),
		.active_o    (d_active),
		.paired_o    (d_paired),
		.pong_o      (d_pong),
		.toggle_o    (d_toggle),
		.low_speed_o (d_low),
		.func_addr_o (d_faddr),
		.endpoint_o  (d_endp),
		.token_o     (d_token),
		.max_pkt_o   (d_maxpkt),
		.total_o     (d_total),
		.poll_due_o  (d_poll_due),
		.iso_due_o   (d_iso_due)
	);

	// frame timing
	wire        sof_w       = frm_cnt_r == 15'(FRAME_CYCLES - 1);

	// list geometry: stride is header plus payload block, in words
	wire [7:0]  stride_w    = 8'h02 + {blk_size_r[9:2]};
	wire [7:0]  base_w      = (list_r == L_APER) ? `UHDS_BASE_APER :
	                          (list_r == L_INT) ? `UHDS_BASE_INT : `UHDS_BASE_ISO;
	wire [7:0]  slot_w      = base_w + 8'(idx_r * stride_w);
	wire [7:0]  sched_addr  = slot_w + {7'h00, state_r == S_RD1};
	wire [3:0]  last_w      = (list_r == L_APER) ? aper_last_r :
	                          (list_r == L_INT) ? int_last_r : iso_last_r;
	wire        at_last     = idx_r == last_w;

	// eligibility of the fetched descriptor
	wire        pong_w      = d_paired & d_pong;
	wire        aper_ok     = ~skip_r[idx_r] & (~pong_w | ping_done_r);
	wire        kind_ok     = (list_r == L_APER) ? aper_ok :
	                          (list_r == L_INT) ? d_poll_due : d_iso_due;
	// list enum order differs from the buffer status bit order, so select by name
	wire        list_on     = (list_r == L_APER) ? list_act_r[`UHDS_BS_APER_ACT] :
	                          (list_r == L_INT) ? list_act_r[`UHDS_BS_INT_ACT] :
	                          list_act_r[`UHDS_BS_ISO_ACT];
	wire        elig_w      = d_active & list_on & kind_ok;

	// write-back of header word 0
	wire        good_w      = cc_r == `UHDS_CC_NO_ERROR;
	wire        sched_we    = state_r == S_WB;
	wire [31:0] sched_wdata = {hdr0_r[31:16], cc_r, 1'b0,
	                           good_w ? ~hdr0_r[`UHDS_H0_TOGGLE] : hdr0_r[`UHDS_H0_TOGGLE],
	                           actual_r};

	// completion events
	wire        aper_done   = sched_we & (list_r == L_APER);
	wire        thr_hit     = aper_done & ((aper_cnt_r + 4'h1) >= thresh_r);
	wire        int_hit     = sched_we & (list_r == L_INT) & (acked_r | ~good_w);
	wire        int_set     = int_hit & ~int_fired_r;

	// wishbone decode
	wire        wb_req      = wb_cyc_i & wb_stb_i & ~ack_r;
	wire [9:0]  wb_word     = wb_adr_i[11:2];
	wire        wb_ram      = wb_word[9:8] == `UHDS_RAM_WIN_SEL;
	wire        ram_busy    = sched_we | sie_wr_en_i;
	// a ram write that collides with the scheduler or engine waits until neither of them writes
	wire        wb_go       = wb_req & ~(wb_ram & wb_we_i & ram_busy);
	wire        wb_wr       = wb_go & wb_we_i & ~wb_ram;
	wire [11:0] wb_off      = {wb_adr_i[11:2], 2'b00};
	wire        wr_bs       = wb_wr & (wb_off == `UHDS_REG_BUF_STATUS);
	wire        wr_blk      = wb_wr & (wb_off == `UHDS_REG_BLK_SIZE);
	wire        wr_skip     = wb_wr & (wb_off == `UHDS_REG_SKIP_MAP);
	wire        wr_alast    = wb_wr & (wb_off == `UHDS_REG_APER_LAST);
	wire        wr_ilast    = wb_wr & (wb_off == `UHDS_REG_INT_LAST);
	wire        wr_slast    = wb_wr & (wb_off == `UHDS_REG_ISO_LAST);
	wire        wr_thr      = wb_wr & (wb_off == `UHDS_REG_IRQ_THRESH);
	wire        wr_irq      = wb_wr & (wb_off == `UHDS_REG_IRQ_STATUS);
	wire        rd_done     = wb_go & ~wb_we_i & ~wb_ram & (wb_off == `UHDS_REG_DONE_MAP);
	wire        pong_line   = (state_r == S_XFER) & pong_w;

	logic [31:0] reg_rdata;
	always_comb begin
		unique case (wb_off)
			`UHDS_REG_BUF_STATUS: reg_rdata = {27'h0, state_r != S_IDLE, pong_line, list_act_r};
			`UHDS_REG_BLK_SIZE:   reg_rdata = {22'h0, blk_size_r};
			`UHDS_REG_SKIP_MAP:   reg_rdata = {16'h0, skip_r};
			`UHDS_REG_DONE_MAP:   reg_rdata = {16'h0, done_r};
			`UHDS_REG_APER_LAST:  reg_rdata = {28'h0, aper_last_r};
			`UHDS_REG_INT_LAST:   reg_rdata = {28'h0, int_last_r};
			`UHDS_REG_ISO_LAST:   reg_rdata = {28'h0, iso_last_r};
			`UHDS_REG_IRQ_THRESH: reg_rdata = {28'h0, thresh_r};
			`UHDS_REG_IRQ_STATUS: reg_rdata = {30'h0, irq_stat_r};
			`UHDS_REG_FRAME_NUM:  reg_rdata = {16'h0, frame_r};
			default:              reg_rdata = 32'h0;
		endcase
	end

	// buffer ram: a scheduler write wins over a same-cycle engine write
	always_ff @(posedge clk_i) begin
		if (sched_we) begin
			ram[sched_addr] <= sched_wdata;
		end else if (sie_wr_en_i) begin
			ram[sie_wr_addr_i] <= sie_wr_data_i;
		end else if (wb_go & wb_we_i & wb_ram) begin
			ram[wb_word[7:0]] <= merge_sel(ram[wb_word[7:0]], wb_dat_i, wb_sel_i);
		end
		sched_q       <= ram[sched_addr];
		sie_rd_data_r <= ram[sie_rd_addr_i];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r    <= 1'b0;
			wb_dat_r <= 32'h0;
		end else begin
			ack_r <= wb_go;
			if (wb_go & ~wb_we_i) begin
				wb_dat_r <= wb_ram ? ram[wb_word[7:0]] : reg_rdata;
			end
		end
	end

	// software registers
	wire [31:0] bs_merged   = merge_sel(32'h0, wb_dat_i, wb_sel_i);
	wire [31:0] blk_merged  = merge_sel({22'h0, blk_size_r}, wb_dat_i, wb_sel_i);
	wire [31:0] skip_merged = merge_sel({16'h0, skip_r}, wb_dat_i, wb_sel_i);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			list_act_r  <= 3'h0;
			blk_size_r  <= `UHDS_RST_BLK_SIZE;
			skip_r      <= `UHDS_RST_SKIP_MAP;
			aper_last_r <= `UHDS_RST_LAST;
			int_last_r  <= `UHDS_RST_LAST;
			iso_last_r  <= `UHDS_RST_LAST;
			thresh_r    <= `UHDS_RST_THRESH;
		end else begin
			if (wr_bs)    list_act_r  <= bs_merged[2:0];
			if (wr_blk)   blk_size_r  <= blk_merged[9:0];
			if (wr_skip)  skip_r      <= skip_merged[15:0];
			if (wr_alast) aper_last_r <= wb_dat_i[3:0];
			if (wr_ilast) int_last_r  <= wb_dat_i[3:0];
			if (wr_slast) iso_last_r  <= wb_dat_i[3:0];
			if (wr_thr)   thresh_r    <= wb_dat_i[3:0];
		end
	end

	// status: hardware set wins over a same-cycle software clear
	logic [15:0] done_set;
	assign done_set = aper_done ? (16'h0001 << idx_r) : 16'h0000;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			done_r      <= 16'h0;
			irq_stat_r  <= 2'h0;
			aper_cnt_r  <= 4'h0;
			int_fired_r <= 1'b0;
			ping_done_r <= 1'b0;
		end else begin
			done_r <= (rd_done ? 16'h0 : done_r) | done_set;
			irq_stat_r <= (irq_stat_r & ~(wr_irq ? wb_dat_i[1:0] : 2'b00)) |
			              {int_set, thr_hit};
			if (thr_hit) aper_cnt_r <= 4'h0;
			else if (aper_done) aper_cnt_r <= aper_cnt_r + 4'h1;
			if (int_set) int_fired_r <= 1'b1;
			else if (sof_w) int_fired_r <= 1'b0;
			if (aper_done & d_paired & good_w) ping_done_r <= ~d_pong;
		end
	end

	// frame counter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frm_cnt_r    <= 15'h0;
			frame_r      <= 16'h0;
			frame_pend_r <= 1'b0;
		end else begin
			frm_cnt_r    <= sof_w ? 15'h0 : frm_cnt_r + 15'h1;
			if (sof_w) frame_r <= frame_r + 16'h1;
			frame_pend_r <= sof_w | (frame_pend_r & ~(state_r == S_IDLE));
		end
	end

	// list walker; periodic lists once per frame, aperiodic list round robin
	always_comb begin
		state_nxt = state_r;
		list_nxt  = list_r;
		idx_nxt   = idx_r;
		unique case (state_r)
			S_IDLE: begin
				if (frame_pend_r) begin
					list_nxt  = L_INT;
					idx_nxt   = 4'h0;
					state_nxt = S_RD0;
				end else if (list_act_r[`UHDS_BS_APER_ACT]) begin
					list_nxt  = L_APER;
					idx_nxt   = aper_idx_r;
					state_nxt = S_RD0;
				end
			end
			S_RD0:   state_nxt = S_RD1;
			S_RD1:   state_nxt = S_LATCH;
			S_LATCH: state_nxt = S_EVAL;
			S_EVAL:  state_nxt = elig_w ? S_XFER : S_NEXT;
			S_XFER: begin
				if (txn_done_i) state_nxt = txn_nak_i ? S_NEXT : S_WB;
			end
			S_WB:    state_nxt = S_NEXT;
			S_NEXT: begin
				// back to idle after each aperiodic slot so a new frame is seen at once
				if (list_r == L_APER) begin
					state_nxt = S_IDLE;
				end else if (!at_last) begin
					idx_nxt   = idx_r + 4'h1;
					state_nxt = S_RD0;
				end else if (list_r == L_INT) begin
					list_nxt  = L_ISO;
					idx_nxt   = 4'h0;
					state_nxt = S_RD0;
				end else begin
					state_nxt = S_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r    <= S_IDLE;
			list_r     <= L_APER;
			idx_r      <= 4'h0;
			aper_idx_r <= 4'h0;
		end else begin
			state_r <= state_nxt;
			list_r  <= list_nxt;
			idx_r   <= idx_nxt;
			if (state_r == S_NEXT && list_r == L_APER) aper_idx_r <= at_last ? 4'h0 : idx_r + 4'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hdr0_r   <= 32'h0;
			hdr1_r   <= 32'h0;
			cc_r     <= 4'h0;
			actual_r <= 10'h0;
			acked_r  <= 1'b0;
		end else begin
			if (state_r == S_RD1) hdr0_r <= sched_q;
			if (state_r == S_LATCH) hdr1_r <= sched_q;
			if (state_r == S_XFER && txn_done_i) begin
				cc_r     <= txn_cc_i;
				actual_r <= txn_actual_i;
				acked_r  <= txn_acked_i;
			end
		end
	end

	assign wb_ack_o        = ack_r;
	assign wb_dat_o        = wb_dat_r;
	assign txn_req_o       = state_r == S_XFER;
	assign txn_func_addr_o = d_faddr;
	assign txn_endpoint_o  = d_endp;
	assign txn_token_o     = d_token;
	assign txn_toggle_o    = d_toggle;
	assign txn_low_speed_o = d_low;
	assign txn_max_pkt_o   = d_maxpkt;
	assign txn_total_o     = d_total;
	assign txn_data_ptr_o  = slot_w + 8'h02;
	assign sie_rd_data_o   = sie_rd_data_r;
	assign sof_o           = sof_w;
	assign irq_o           = |irq_stat_r;

	a_skip_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_r == S_EVAL && list_r == L_APER && skip_r[idx_r]) |=> state_r == S_NEXT)
		else $error("skipped descriptor was issued");
	a_pong_after_ping: assert property (@(posedge clk_i) disable iff (rst_i)
		(txn_req_o && list_r == L_APER && pong_w) |-> ping_done_r)
		else $error("pong issued before ping");
	a_iso_frame_match: assert property (@(posedge clk_i) disable iff (rst_i)
		($rose(txn_req_o) && list_r == L_ISO) |-> hdr1_r[31:24] == frame_r[7:0])
		else $error("iso descriptor issued in wrong frame");
	a_poll_phase: assert property (@(posedge clk_i) disable iff (rst_i)
		($rose(txn_req_o) && list_r == L_INT) |->
		(hdr1_r[31:29] == 3'h0 ||
		 ((frame_r[4:0] ^ hdr1_r[28:24]) & 5'((6'h01 << hdr1_r[31:29]) - 6'h01)) == 5'h00 ||
		 hdr1_r[31:29] > 3'h5))
		else $error("interrupt descriptor issued off its phase");
	a_int_once_frame: assert property (@(posedge clk_i) disable iff (rst_i)
		(int_fired_r && !sof_w) |=> !int_set || $past(sof_w))
		else $error("interrupt list irq raised twice in one frame");
	a_done_map_set: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_r == S_WB && list_r == L_APER) |=> done_r[$past(idx_r)])
		else $error("done bit not set after completion");
	a_active_cleared: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(state_r == S_WB) |-> ##1 ram[$past(sched_addr)][11] == 1'b0 &&
		ram[$past(sched_addr)][15:12] == $past(cc_r))
		else $error("active bit or completion code not written back");
	a_toggle_flip: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_r == S_WB && cc_r == 4'h0) |=> ram[$past(sched_addr)][10] != $past(hdr0_r[10]))
		else $error("toggle not flipped after good packet");
	a_thresh_irq: assert property (@(posedge clk_i) disable iff (rst_i)
		(aper_done && aper_cnt_r + 4'h1 >= thresh_r) |=> irq_stat_r[0] && aper_cnt_r == 4'h0)
		else $error("threshold reached without irq");
	a_int_irq_cause: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(irq_stat_r[1]) |-> $past(state_r) == S_WB && $past(list_r) == L_INT &&
		($past(acked_r) || $past(cc_r) != 4'h0))
		else $error("interrupt list irq without ack or error");
	a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("bus ack longer than one cycle");

endmodule

/* tb/uhds_func_model.sv */
// serial engine and attached function model answering scheduler transactions
`timescale 1ns/1ps

module uhds_func_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       req_i,
	input  wire logic [9:0] total_i,
	input  wire logic       slow_i,
	output logic            done_o = 1'b0,
	output logic            acked_o = 1'b0,
	output logic            nak_o = 1'b0,
	output logic [3:0]      cc_o = 4'h0,
	output logic [9:0]      actual_o = 10'h0
);
	logic [3:0] cnt_r = 4'h0;

	// qualifiers toggle outside done so a stale value is never mistaken for an answer
	always @(posedge clk_i) begin
		done_o   <= 1'b0;
		acked_o  <= ~acked_o;
		cc_o     <= ~cc_o;
		actual_o <= ~actual_o;
		if (rst_i) begin
			cnt_r <= 4'h0;
		end else if (req_i && !done_o) begin
			cnt_r <= cnt_r + 4'h1;
			if (cnt_r == (slow_i ? 4'h6 : 4'h0)) begin
				cnt_r    <= 4'h0;
				done_o   <= 1'b1;
				acked_o  <= 1'b1;
				cc_o     <= 4'h0;
				actual_o <= total_i;
			end
		end
	end
endmodule

/* tb/usb_host_descriptor_scheduler_test.sv */
// self-checking bench for the usb host descriptor scheduler
`timescale 1ns/1ps
`include "uhds_defines.svh"

module usb_host_descriptor_scheduler_test;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, slow = 1'b0;
	logic [11:0] adr = 12'h0;
	logic [31:0] wdat = 32'h0, rdat, dat_o;
	logic        ack, req, tog, ls, done, nak, acked, irq;
	logic [6:0]  fa;
	logic [3:0]  ep, cc;
	logic [1:0]  tok;
	logic [9:0]  mp, tot, act;
	logic [7:0]  ptr;
	logic [7:0]  sra = 8'h0;
	logic [31:0] srd;
	logic [3:0]  sel = 4'hf;
	int          fail_count = 0;
	int          check_count = 0;

	uhds_scheduler #(.FRAME_CYCLES(400)) uut (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .txn_req_o(req),
		.txn_func_addr_o(fa), .txn_endpoint_o(ep), .txn_token_o(tok), .txn_toggle_o(tog),
		.txn_low_speed_o(ls), .txn_max_pkt_o(mp), .txn_total_o(tot), .txn_data_ptr_o(ptr),
		.txn_done_i(done), .txn_nak_i(nak), .txn_acked_i(acked), .txn_cc_i(cc),
		.txn_actual_i(act), .sie_rd_addr_i(sra), .sie_rd_data_o(srd), .sie_wr_en_i(1'b0),
		.sie_wr_addr_i(8'h0), .sie_wr_data_i(32'h0), .sof_o(), .irq_o(irq));

	uhds_func_model fm (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .total_i(tot),
		.slow_i(slow), .done_o(done), .acked_o(acked), .nak_o(nak), .cc_o(cc),
		.actual_o(act));

	always #25 clk_i = ~clk_i;

	task automatic report_and_stop;
		if (fail_count == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one classic cycle; ack and data are taken at the edge that samples ack
	task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 40);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
		if (n >= 40) begin
			fail_count++;
			report_and_stop();
		end
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask

	task automatic wait_req(input logic lvl);
		int n;
		n = 0;
		while (req !== lvl && n < 4000) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 4000) begin
			fail_count++;
			report_and_stop();
		end
	endtask

	task automatic s_reset;
		rd(`UHDS_REG_BLK_SIZE, 32'h8);
		rd(`UHDS_REG_SKIP_MAP, 32'hffff);
		sel <= 4'h2;
		wb(1'b1, `UHDS_REG_SKIP_MAP, 32'h0000_00ff);
		sel <= 4'hf;
		rd(`UHDS_REG_SKIP_MAP, 32'h00ff);
		rd(`UHDS_REG_FRAME_NUM, 32'h0);
		rd(`UHDS_REG_IRQ_THRESH, 32'h1);
		rd(12'h030, 32'h0);
		chk({31'h0, irq}, 32'h0);
	endtask

	// slot 1 is active but skipped; slot 0 is a low-speed setup
	task automatic s_single;
		wb(1'b1, 12'h400, 32'h3408_0800);
		wb(1'b1, 12'h404, 32'h0055_0008);
		wb(1'b1, 12'h408, 32'h0100_0680);
		wb(1'b1, 12'h40c, 32'h0012_0000);
		wb(1'b1, 12'h410, 32'h3008_0800);
		wb(1'b1, 12'h414, 32'h0055_0008);
		wb(1'b1, `UHDS_REG_APER_LAST, 32'h1);
		wb(1'b1, `UHDS_REG_SKIP_MAP, 32'hfffe);
		wb(1'b1, `UHDS_REG_BUF_STATUS, 32'h1);
		wait_req(1'b1);
		chk({25'h0, fa}, 32'h55);
		chk({30'h0, tok, ls}, 32'h1);
		chk({22'h0, tot}, 32'h8);
		chk({24'h0, ptr}, 32'h2);
		wait_req(1'b0);
		repeat (3) @(posedge clk_i);
		rd(12'h400, 32'h3408_0408);
		rd(12'h410, 32'h3008_0800);
		sra <= 8'h04;
		repeat (2) @(posedge clk_i);
		chk(srd, 32'h3008_0800);
		rd(`UHDS_REG_DONE_MAP, 32'h1);
		chk({31'h0, irq}, 32'h1);
		wb(1'b1, `UHDS_REG_BUF_STATUS, 32'h0);
		wb(1'b1, `UHDS_REG_IRQ_STATUS, 32'h1);
		chk({31'h0, irq}, 32'h0);
	endtask

	// pong sits ahead of its ping in the list and must wait for it
	task automatic s_pair;
		slow <= 1'b1;
		wb(1'b1, `UHDS_REG_IRQ_THRESH, 32'h2);
		wb(1'b1, 12'h400, 32'h3008_0800);
		wb(1'b1, 12'h404, 32'h0055_c008);
		wb(1'b1, 12'h414, 32'h0055_8008);
		wb(1'b1, `UHDS_REG_SKIP_MAP, 32'hfffc);
		wb(1'b1, `UHDS_REG_BUF_STATUS, 32'h1);
		wait_req(1'b1);
		chk({24'h0, ptr}, 32'h6);
		wb(1'b0, `UHDS_REG_BUF_STATUS, 32'h0);
		chk({31'h0, rdat[3]}, 32'h0);
		wait_req(1'b0);
		repeat (3) @(posedge clk_i);
		chk({31'h0, irq}, 32'h0);
		wait_req(1'b1);
		chk({24'h0, ptr}, 32'h2);
		wb(1'b0, `UHDS_REG_BUF_STATUS, 32'h0);
		chk({31'h0, rdat[3]}, 32'h1);
		wait_req(1'b0);
		repeat (3) @(posedge clk_i);
		chk({31'h0, irq}, 32'h1);
		rd(`UHDS_REG_DONE_MAP, 32'h3);
	endtask

	// interrupt slot polls odd frames; iso slot waits for a chosen frame
	task automatic s_periodic;
		logic [7:0] f;
		wb(1'b1, `UHDS_REG_BUF_STATUS, 32'h0);
		wb(1'b1, `UHDS_REG_IRQ_STATUS, 32'h3);
		wb(1'b1, 12'h600, 32'h3008_0800);
		wb(1'b1, 12'h604, 32'h2155_0808);
		wb(1'b1, `UHDS_REG_BUF_STATUS, 32'h2);
		wait_req(1'b1);
		chk({30'h0, tok}, 32'h2);
		wb(1'b0, `UHDS_REG_FRAME_NUM, 32'h0);
		chk({31'h0, rdat[0]}, 32'h1);
		wait_req(1'b0);
		repeat (3) @(posedge clk_i);
		rd(`UHDS_REG_IRQ_STATUS, 32'h2);
		rd(12'h600, 32'h3008_0408);
		wb(1'b1, `UHDS_REG_IRQ_STATUS, 32'h2);
		chk({31'h0, irq}, 32'h0);
		wb(1'b0, `UHDS_REG_FRAME_NUM, 32'h0);
		f = rdat[7:0] + 8'h02;
		wb(1'b1, 12'h700, 32'h3008_0800);
		wb(1'b1, 12'h704, {f, 24'h55_0408});
		wb(1'b1, `UHDS_REG_BUF_STATUS, 32'h4);
		wait_req(1'b1);
		wb(1'b0, `UHDS_REG_FRAME_NUM, 32'h0);
		chk({24'h0, rdat[7:0]}, {24'h0, f});
		wait_req(1'b0);
	endtask

	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		s_reset();
		s_single();
		s_pair();
		s_periodic();
		report_and_stop();
	end
endmodule
